// ---- design/imm_pkg.sv ----
// Constants, types and register map of the indexed move and multiply unit
// ********************************************************************
// Behaviour
// - Opcode 0x3 is the indexed move, opcode 0x41 the multiply.
// - Multiply puts src0 times src1 into each enabled channel.
// - Move source register comes from index 0 plus offset only.
// - Each move channel takes its subregister from its own index.
// - The indexed move never touches the accumulator.
// - Move fills from element zero; offset only gates enables.
// - Byte move: byte k picked by index k bits 4:0.
// - Word move: bytes 2k,2k+1 picked by index k bits 4:1.
// - Dword move: bytes 4k..4k+3 picked by index k bits 4:2.
// - Effective index is index bits 4:0 plus offset bits 4:0.
// - Dword multiply uses src0 low 16 bits; 48-bit accumulator.
// - Float special cases follow the selected float mode.
// - IEEE: NaN cases, denormal as zero, zero/inf get sign xor.
// - IEEE: like-signed finite product is positive, inf on overflow.
// ********************************************************************
`default_nettype none

package imm_pkg;
   // Opcodes and element types; type bit 0 marks signed integers
   localparam logic [6:0]  OP_MOVI    = 7'h03;
   localparam logic [6:0]  OP_MUL     = 7'h41;
   localparam logic [2:0]  TY_UD      = 3'h0;
   localparam logic [2:0]  TY_D       = 3'h1;
   localparam logic [2:0]  TY_UW      = 3'h2;
   localparam logic [2:0]  TY_W       = 3'h3;
   localparam logic [2:0]  TY_UB      = 3'h4;
   localparam logic [2:0]  TY_B       = 3'h5;
   localparam logic [2:0]  TY_F       = 3'h6;
   localparam int          CHANNELS   = 8;
   localparam int          NUM_REGS   = 4;
   localparam int          REG_WORDS  = 8;
   // Register byte offsets
   localparam logic [11:0] A_CTRL     = 12'h000;
   localparam logic [11:0] A_MASK     = 12'h004;
   localparam logic [11:0] A_IMM      = 12'h008;
   localparam logic [11:0] A_STAT     = 12'h00c;
   localparam logic [11:0] A_IDX      = 12'h020;
   localparam logic [11:0] A_GRF      = 12'h100;
   localparam logic [11:0] A_ACCL     = 12'h200;
   localparam logic [11:0] A_ACCH     = 12'h220;
   localparam logic [2:0]  HSIZE_WORD = 3'h2;
   // Field positions, masks and reset values
   localparam int          CTRL_GO    = 31;
   localparam logic [31:0] CTRL_WMASK = 32'h073fff7f;
   localparam int          STAT_DONE  = 0;
   localparam int          STAT_ILL   = 1;
   // Float constants
   localparam logic [31:0] NAN_Q      = 32'h7fc00000;
   localparam logic [30:0] INF_M      = 31'h7f800000;
   localparam logic [30:0] FMAX       = 31'h7f7fffff;

   typedef struct packed {
      logic       go;
      logic [3:0] rsv_hi;
      logic [2:0] dst_off;
      logic [1:0] rsv_mid;
      logic [1:0] src1_reg;
      logic [1:0] src0_reg;
      logic [1:0] dst_reg;
      logic       fp_alt;
      logic [2:0] ty;
      logic [3:0] exec_size;
      logic       rsv_lo;
      logic [6:0] opcode;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '0;
endpackage : imm_pkg

`default_nettype wire

// ---- design/indexed_move_and_multiply_unit.sv ----
// Indexed move and multiply execution slice with AHB-Lite registers
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`default_nettype none

module indexed_move_and_multiply_unit
   import imm_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp
);

   // ****************************************************************
   // State
   // ****************************************************************
   logic                         dp_q;
   logic                         wr_q;
   logic                         rd_wait_q;
   logic                         exec_q;
   logic [11:0]                  addr_q;
   logic [31:0]                  hrdata_q;
   ctrl_t                        ctrl_q;
   logic [7:0]                   mask_q;
   logic [12:0]                  imm_q;
   logic [1:0]                   stat_q;
   logic [12:0]                  idx_q [CHANNELS];
   logic [31:0]                  grf_q [NUM_REGS*REG_WORDS];
   logic [CHANNELS-1:0][47:0]    acc_q;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   // Exec and read fetch each cost a wait state
   logic        ready;
   logic        accept;
   logic        commit;
   logic [11:0] a;
   logic        is_ctrl;
   logic        is_mask;
   logic        is_imm;
   logic        is_stat;
   logic        is_idx;
   logic        is_grf;
   logic        is_accl;
   logic        is_acch;
   ctrl_t       ctrl_w;
   logic [31:0] rd_mux;
   assign ready   = !exec_q && !rd_wait_q;
   assign accept  = hsel && htrans[1] && hready && hsize == HSIZE_WORD;
   assign commit  = dp_q && wr_q && ready;
   assign a       = addr_q;
   assign is_ctrl = a == A_CTRL;
   assign is_mask = a == A_MASK;
   assign is_imm  = a == A_IMM;
   assign is_stat = a == A_STAT;
   assign is_idx  = a[11:5] == A_IDX[11:5];
   assign is_grf  = a[11:7] == A_GRF[11:7];
   assign is_accl = a[11:5] == A_ACCL[11:5];
   assign is_acch = a[11:5] == A_ACCH[11:5];
   assign ctrl_w  = hwdata & CTRL_WMASK;

   // Unmapped addresses read zero and ignore writes
   assign rd_mux =
      is_ctrl ? ctrl_q :
      is_mask ? {24'h0, mask_q} :
      is_imm  ? {19'h0, imm_q} :
      is_stat ? {30'h0, stat_q} :
      is_idx  ? {19'h0, idx_q[a[4:2]]} :
      is_grf  ? grf_q[a[6:2]] :
      is_accl ? acc_q[a[4:2]][31:0] :
      is_acch ? {16'h0, acc_q[a[4:2]][47:32]} :
      32'h0;

   assign hrdata    = hrdata_q;
   assign hreadyout = ready;
   assign hresp     = 1'b0;

   // Data phase tracking; reads hold off while an exec is in flight
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_q      <= 1'b0;
         wr_q      <= 1'b0;
         addr_q    <= 12'h000;
         rd_wait_q <= 1'b0;
         hrdata_q  <= 32'h0;
      end else begin
         if (accept) begin
            dp_q   <= 1'b1;
            wr_q   <= hwrite;
            addr_q <= haddr[11:0];
         end else if (ready) begin
            dp_q <= 1'b0;
         end
         rd_wait_q <= (accept && !hwrite) || (rd_wait_q && exec_q);
         if (rd_wait_q && !exec_q) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   // Go bit is a one-shot; it launches one execute cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= CTRL_RST;
         mask_q <= 8'h00;
         imm_q  <= 13'h0000;
         exec_q <= 1'b0;
      end else begin
         exec_q <= commit && is_ctrl && hwdata[CTRL_GO];
         if (commit && is_ctrl) ctrl_q <= ctrl_w;
         if (commit && is_mask) mask_q <= hwdata[7:0];
         if (commit && is_imm)  imm_q  <= hwdata[12:0];
      end
   end

   // Address index registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < CHANNELS; i++) idx_q[i] <= 13'h0000;
      end else if (commit && is_idx) begin
         idx_q[a[4:2]] <= hwdata[12:0];
      end
   end

   // ****************************************************************
   // Operand fetch and decode
   // ****************************************************************
   logic                is_movi;
   logic                is_mul;
   logic                op_ok;
   logic                is_flt;
   logic                sgn;
   logic [1:0]          lg;
   logic [4:0]          sz_m;
   logic [12:0]         eff0;
   logic [4:0]          esub0;
   logic [1:0]          mv_reg;
   logic [CHANNELS-1:0] chan_en;
   logic [255:0]        src0_v;
   logic [255:0]        src1_v;
   logic [255:0]        mv_v;
   assign is_movi = ctrl_q.opcode == OP_MOVI;
   assign is_mul  = ctrl_q.opcode == OP_MUL;
   assign op_ok   = is_movi || is_mul;
   assign is_flt  = ctrl_q.ty == TY_F;
   assign sgn     = ctrl_q.ty[0];
   assign lg      = (ctrl_q.ty == TY_UB || ctrl_q.ty == TY_B) ? 2'd0 :
                    (ctrl_q.ty == TY_UW || ctrl_q.ty == TY_W) ? 2'd1 :
                    2'd2;
   assign sz_m    = (5'h01 << lg) - 5'h01;
   // One register for all channels, from index 0 only
   assign eff0    = idx_q[0] + imm_q;
   assign mv_reg  = eff0[6:5];
   assign esub0   = idx_q[0][4:0] + imm_q[4:0];

   // Destination offset only gates channels; eight indices cap the size
   always_comb begin
      for (int n = 0; n < CHANNELS; n++) begin
         chan_en[n] = mask_q[n] && 4'(n) < ctrl_q.exec_size
                      && 3'(n) >= ctrl_q.dst_off;
      end
   end

   // Whole register views of the sources
   always_comb begin
      for (int w = 0; w < REG_WORDS; w++) begin
         src0_v[32*w +: 32] = grf_q[{ctrl_q.src0_reg, 3'(w)}];
         src1_v[32*w +: 32] = grf_q[{ctrl_q.src1_reg, 3'(w)}];
         mv_v[32*w +: 32]   = grf_q[{mv_reg, 3'(w)}];
      end
   end

   // ****************************************************************
   // Arithmetic
   // ****************************************************************
   // Sign or zero extend the low 8, 16 or 32 bits
   function automatic logic [32:0] ext(
      input logic [31:0] x,
      input logic [1:0]  l,
      input logic        sg
   );
      logic [32:0] r;
      case (l)
         2'd0:    r = {{25{sg & x[7]}}, x[7:0]};
         2'd1:    r = {{17{sg & x[15]}}, x[15:0]};
         default: r = {sg & x[31], x};
      endcase
      return r;
   endfunction : ext

   // Single precision multiply, truncating, denormals flushed
   function automatic logic [31:0] fmul(
      input logic [31:0] x,
      input logic [31:0] y,
      input logic        alt
   );
      logic        s;
      logic        zx;
      logic        zy;
      logic        ix;
      logic        iy;
      logic        nx;
      logic        ny;
      logic [47:0] p;
      logic [9:0]  e;
      logic [22:0] m;
      logic [31:0] r;
      s  = x[31] ^ y[31];
      zx = x[30:23] == 8'h00;
      zy = y[30:23] == 8'h00;
      ix = x[30:23] == 8'hff;
      iy = y[30:23] == 8'hff;
      nx = ix && x[22:0] != 23'h0;
      ny = iy && y[22:0] != 23'h0;
      p  = {24'h0, 1'b1, x[22:0]} * {24'h0, 1'b1, y[22:0]};
      e  = {2'b00, x[30:23]} + {2'b00, y[30:23]} - 10'd127
           + {9'h000, p[47]};
      m  = p[47] ? p[46:24] : p[45:23];
      if (!alt && (nx || ny || (ix && zy) || (zx && iy))) begin
         r = NAN_Q;
      end else if (zx || zy) begin
         r = {s, 31'h0};
      end else if (ix || iy) begin
         r = {s, alt ? FMAX : INF_M};
      end else if (e[9] || e == 10'h000) begin
         r = {s, 31'h0};
      end else if (e >= 10'd255) begin
         r = {s, alt ? FMAX : INF_M};
      end else begin
         r = {s, e[7:0], m};
      end
      return r;
   endfunction : fmul

   // ****************************************************************
   // Execute: result bytes, byte enables, accumulator update
   // ****************************************************************
   logic [255:0]              res_v;
   logic [31:0]               be;
   logic [CHANNELS-1:0][47:0] acc_d;
   logic [CHANNELS-1:0]       acc_we;
   logic [4:0]                sub;
   logic [4:0]                bi;
   logic [31:0]               x0;
   logic [31:0]               x1;
   logic [32:0]               a_s;
   logic [32:0]               b_s;
   logic signed [65:0]        p;
   logic [31:0]               r32;

   // Elements are packed from byte zero regardless of destination offset
   always_comb begin
      res_v  = '0;
      be     = '0;
      acc_d  = acc_q;
      acc_we = '0;
      sub    = 5'h00;
      bi     = 5'h00;
      x0     = 32'h0;
      x1     = 32'h0;
      a_s    = '0;
      b_s    = '0;
      p      = '0;
      r32    = 32'h0;
      for (int n = 0; n < CHANNELS; n++) begin
         sub = idx_q[n][4:0] + imm_q[4:0];
         x0  = src0_v[{5'(n << lg), 3'b000} +: 32];
         x1  = src1_v[{5'(n << lg), 3'b000} +: 32];
         // Dword sources keep only 16 bits of src0
         a_s = ext(x0, (lg == 2'd0) ? 2'd0 : 2'd1, sgn);
         b_s = ext(x1, lg, sgn);
         p   = $signed(a_s) * $signed(b_s);
         r32 = is_flt ? fmul(x0, x1, ctrl_q.fp_alt) : p[31:0];
         if (is_mul && !is_flt && chan_en[n]) begin
            acc_d[n]  = p[47:0];
            acc_we[n] = 1'b1;
         end
         for (int j = 0; j < 4; j++) begin
            if (5'(j) <= sz_m) begin
               bi = 5'((n << lg) + j);
               // Size mask clears 0, 1 or 2 low bits of the pick
               res_v[{bi, 3'b000} +: 8] = is_movi ?
                  mv_v[{(sub & ~sz_m) | 5'(j), 3'b000} +: 8]
                  : r32[8*j +: 8];
               be[bi] = chan_en[n] && op_ok;
            end
         end
      end
   end

   // Register file: bus writes and execute never share a cycle
   always_ff @(posedge hclk) begin
      if (commit && is_grf) begin
         grf_q[a[6:2]] <= hwdata;
      end else if (exec_q) begin
         for (int w = 0; w < REG_WORDS; w++) begin
            for (int b = 0; b < 4; b++) begin
               if (be[4*w+b]) begin
                  grf_q[{ctrl_q.dst_reg, 3'(w)}][8*b +: 8]
                     <= res_v[32*w+8*b +: 8];
               end
            end
         end
      end
   end

   // Accumulator follows integer multiplies only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_q <= '0;
      end else if (exec_q && is_mul) begin
         for (int n = 0; n < CHANNELS; n++) begin
            if (acc_we[n]) acc_q[n] <= acc_d[n];
         end
      end
   end

   // Sticky done and error; a set beats a same-cycle clear
   logic [1:0] stat_set;
   logic [1:0] stat_clr;
   assign stat_set = {exec_q && !op_ok, exec_q && op_ok};
   assign stat_clr = (commit && is_stat) ? hwdata[1:0] : 2'b00;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) stat_q <= 2'b00;
      else          stat_q <= (stat_q & ~stat_clr) | stat_set;
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   logic [31:0] dst_w0;
   logic        ex_f;
   assign dst_w0 = grf_q[{ctrl_q.dst_reg, 3'd0}];
   assign ex_f   = exec_q && is_mul && is_flt && chan_en[0];

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   illegal_op_a: assert property (
      exec_q && !op_ok |=> stat_q[STAT_ILL] && $stable(dst_w0))
      else $error("unknown opcode not flagged or wrote");
   mul_word_a: assert property (
      exec_q && is_mul && ctrl_q.ty == TY_UW && chan_en[0]
      |=> dst_w0[15:0] == $past(16'(src0_v[15:0] * src1_v[15:0])))
      else $error("word product wrong");
   mul_acc48_a: assert property (
      exec_q && is_mul && ctrl_q.ty == TY_UD && chan_en[0]
      |=> acc_q[0] == $past(48'(src0_v[15:0]) * 48'(src1_v[31:0])))
      else $error("dword accumulator product wrong");
   acc_hold_a: assert property (
      exec_q && is_movi |=> $stable(acc_q))
      else $error("move changed accumulator");
   chan_keep_a: assert property (
      exec_q && !chan_en[0] && lg == 2'd2 |=> $stable(dst_w0))
      else $error("disabled channel written");
   movi_byte_a: assert property (
      exec_q && is_movi && lg == 2'd0 && chan_en[0]
      |=> dst_w0[7:0] == $past(mv_v[{esub0, 3'b000} +: 8]))
      else $error("byte move picked wrong byte");
   movi_word_a: assert property (
      exec_q && is_movi && lg == 2'd1 && chan_en[0]
      |=> dst_w0[15:0] == $past(mv_v[{esub0[4:1], 4'h0} +: 16]))
      else $error("word move picked wrong half");
   movi_dword_a: assert property (
      exec_q && is_movi && lg == 2'd2 && chan_en[0]
      |=> dst_w0 == $past(grf_q[{mv_reg, esub0[4:2]}]))
      else $error("dword move picked wrong word");
   fp_nan_a: assert property (
      ex_f && !ctrl_q.fp_alt && src0_v[30:23] == 8'hff
      && src0_v[22:0] != 23'h0 |=> dst_w0 == NAN_Q)
      else $error("NaN operand gave no NaN");
   fp_ovf_a: assert property (
      ex_f && !ctrl_q.fp_alt && src0_v[31:0] == 32'h7f000000
      && src1_v[31:0] == 32'h7f000000 |=> dst_w0 == {1'b0, INF_M})
      else $error("overflow did not give plus infinity");
   fp_alt_a: assert property (
      ex_f && ctrl_q.fp_alt && src0_v[30:23] == 8'hff
      && src1_v[31:0] == 32'h3f800000 |=> dst_w0[30:0] == FMAX)
      else $error("alternate mode not clamped to fmax");

endmodule : indexed_move_and_multiply_unit

`default_nettype wire

// ---- tb/indexed_move_and_multiply_unit_tb_top.sv ----
// Self-checking bench for the indexed move and multiply unit
`default_nettype none

module indexed_move_and_multiply_unit_tb_top
   import imm_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [31:0] c;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] e;
   } row_t;

   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   int          err_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   row_t        rows [14];
   logic [4:0]  sub [8];
   logic [31:0] rd;

   indexed_move_and_multiply_unit indexed_move_and_multiply_unit_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp));

   issue_master issue_master_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata));

   // 125 MHz clock
   initial hclk = 1'b0;
   always #4 hclk = ~hclk;

   // Cut a hang short well beyond the expected several hundred cycles
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         err_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (err_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input string nm, input logic [31:0] exp,
                        input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] v;
      issue_master_i.xfer(1'b1, a, d, v);
   endtask : wr

   task automatic rchk(input string nm, input logic [11:0] a,
                       input logic [31:0] exp);
      logic [31:0] v;
      issue_master_i.xfer(1'b0, a, 32'h0, v);
      check(nm, exp, v);
   endtask : rchk

   function automatic logic [31:0] mu(input logic [2:0] ty, input logic f);
      return issue_master_i.mk(OP_MUL, ty, 4'h1, f, 2'h2, 3'h0);
   endfunction : mu

   // Move from register 3 into register 1; element size s bytes
   task automatic do_move(input logic [2:0] ty, input int s,
      input logic [3:0] es, input logic [7:0] m, input logic [2:0] off);
      logic [7:0]  eb;
      logic [31:0] ex;
      int          n;
      for (int w = 0; w < 4; w++) wr(A_GRF + 12'(32 + 4*w), 32'ha5a5a5a5);
      wr(A_MASK, {24'h0, m});
      wr(A_CTRL, issue_master_i.mk(OP_MOVI, ty, es, 1'b0, 2'h1, off));
      for (int w = 0; w < 4; w++) begin
         for (int j = 0; j < 4; j++) begin
            n  = (4*w + j) / s;
            eb = 8'(64 + ((((sub[n % 8] + 5) % 32) & ~(s - 1)) | (j % s)));
            ex[8*j +: 8] = (n < es && n >= off && m[n % 8]) ? eb : 8'ha5;
         end
         rchk("move dst", A_GRF + 12'(32 + 4*w), ex);
      end
   endtask : do_move

   // ********************************************************************
   // Main sequence
   // ********************************************************************
   initial begin
      hresetn = 1'b0;
      rows = '{
         '{mu(TY_D, 0),  32'h7777fffe, 32'h00000003, 32'hfffffffa},
         '{mu(TY_UW, 0), 32'h12340007, 32'h56780009, 32'ha5a5003f},
         '{mu(TY_W, 0),  32'h0000fffd, 32'h00000004, 32'ha5a5fff4},
         '{mu(TY_UB, 0), 32'h000000ff, 32'h00000002, 32'ha5a5a5fe},
         '{mu(TY_B, 0),  32'h000000ff, 32'h00000003, 32'ha5a5a5fd},
         '{mu(TY_UD, 0), 32'h0001ffff, 32'hffffffff, 32'hffff0001},
         '{mu(TY_F, 0),  32'h40000000, 32'h40400000, 32'h40c00000},
         '{mu(TY_F, 0),  32'h7f800000, 32'h00000000, 32'h7fc00000},
         '{mu(TY_F, 0),  32'h7f800000, 32'hc0000000, 32'hff800000},
         '{mu(TY_F, 0),  32'h00000001, 32'hc0400000, 32'h80000000},
         '{mu(TY_F, 0),  32'h7f000000, 32'h7f000000, 32'h7f800000},
         '{mu(TY_F, 0),  32'hff000000, 32'hff000000, 32'h7f800000},
         '{mu(TY_F, 0),  32'h7fc00001, 32'h3f800000, 32'h7fc00000},
         '{mu(TY_F, 1),  32'h7f800000, 32'h3f800000, 32'h7f7fffff}};
      for (int n = 0; n < 8; n++) sub[n] = 5'(9*n + 3);
      repeat (2) @(posedge hclk);
      // Bus outputs idle while reset is held
      check("ready rst", 32'h1, {31'h0, hreadyout});
      check("rdata rst", 32'h0, hrdata);
      hresetn <= 1'b1;
      rchk("ctrl rst", A_CTRL, 32'h0);
      rchk("mask rst", A_MASK, 32'h0);
      rchk("acc rst", A_ACCL, 32'h0);
      wr(12'h400, 32'hffffffff);
      rchk("unmapped", 12'h400, 32'h0);
      check("hresp", 32'h0, {31'h0, hresp});
      // Multiply table, one channel; read right after the go write
      wr(A_MASK, 32'h1);
      foreach (rows[i]) begin
         wr(A_GRF, rows[i].a);
         wr(A_GRF + 12'h020, rows[i].b);
         wr(A_GRF + 12'h040, 32'ha5a5a5a5);
         wr(A_CTRL, rows[i].c);
         rchk("mul dst", A_GRF + 12'h40, rows[i].e);
      end
      rchk("acc low", A_ACCL, 32'hffff0001);
      rchk("acc high", A_ACCH, 32'h0000fffe);
      // Disabled channel and unknown opcode leave the destination alone
      wr(A_MASK, 32'h0);
      wr(A_GRF + 12'h040, 32'ha5a5a5a5);
      wr(A_CTRL, rows[0].c);
      // The execute cycle right after the go write holds the bus
      @(negedge hclk);
      check("exec wait", 32'h0, {31'h0, hreadyout});
      rchk("masked dst", A_GRF + 12'h040, 32'ha5a5a5a5);
      wr(A_MASK, 32'h1);
      wr(A_CTRL, issue_master_i.mk(7'h7e, TY_UD, 4'h1, 1'b0, 2'h2, 3'h0));
      rchk("bad op dst", A_GRF + 12'h040, 32'ha5a5a5a5);
      issue_master_i.xfer(1'b0, A_STAT, 32'h0, rd);
      check("bad op flag", 32'h2, rd & 32'h2);
      wr(A_STAT, 32'h3);
      rchk("stat clear", A_STAT, 32'h0);
      // Indexed moves: all indices in register 3, sums wrap mod 32
      for (int w = 0; w < 8; w++) begin
         wr(A_GRF + 12'(96 + 4*w), 32'h43424140 + 32'h04040404 * w);
      end
      for (int n = 0; n < 8; n++) begin
         wr(A_IDX + 12'(4*n), {25'h0, 2'h3, sub[n]});
      end
      wr(A_IMM, 32'h5);
      do_move(TY_UB, 1, 4'h8, 8'hf5, 3'h2);
      do_move(TY_B, 1, 4'h6, 8'h3b, 3'h0);
      do_move(TY_W, 2, 4'h4, 8'h0f, 3'h0);
      do_move(TY_F, 4, 4'h3, 8'h07, 3'h1);
      do_move(TY_D, 4, 4'h2, 8'h03, 3'h0);
      rchk("acc kept", A_ACCL, 32'hffff0001);
      // Reset in mid-run clears the control registers again
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      check("ready rerst", 32'h1, {31'h0, hreadyout});
      check("rdata rerst", 32'h0, hrdata);
      rchk("mask rerst", A_MASK, 32'h0);
      rchk("acc rerst", A_ACCL, 32'h0);
      tally_and_finish();
   end
endmodule : indexed_move_and_multiply_unit_tb_top

`default_nettype wire

// ---- tb/issue_master.sv ----
// Issue-side bus master that feeds operands and instructions to the unit
`default_nettype none

module issue_master
   import imm_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite master side
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = HSIZE_WORD;
      hwdata = 32'h0;
   end

   // One single word transfer; hready is judged at the negedge before the
   // sampling edge, where it is settled, so no edge race decides the wait
   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {20'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= HSIZE_WORD;
      do @(negedge hclk); while (hready !== 1'b1);
      @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wr ? wd : ~hwdata;
      do @(negedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      @(posedge hclk);
      // Released data line must not keep a stale copy
      hwdata <= ~hwdata;
   endtask : xfer

   // Instruction word; the bus form only expresses a packed destination
   // and one-by-one regioning, never 16-element mode
   function automatic logic [31:0] mk(input logic [6:0] op,
      input logic [2:0] ty, input logic [3:0] es, input logic alt,
      input logic [1:0] dreg, input logic [2:0] off);
      ctrl_t c;
      c           = CTRL_RST;
      c.go        = 1'b1;
      c.opcode    = op;
      c.ty        = ty;          // one type for source and dest
      c.exec_size = (op == OP_MOVI && es > 4'h8) ? 4'h8 : es;
      c.fp_alt    = alt;
      c.dst_reg   = dreg;  // whole registers, 32-byte aligned
      c.src0_reg  = 2'h0;
      c.src1_reg  = 2'h1;
      c.dst_off   = off;
      return c;
   endfunction : mk
endmodule : issue_master

`default_nettype wire
